// File: phy_an_regs_pkg.sv
// Package with register indices, field positions, reset values and carriers of the PHY page and status registers.
package phy_an_regs_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int IDX_W  = ADDR_W - 2;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_BASE  = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EXP   = 6'h06;
  localparam logic [IDX_W-1:0] IDX_NPTX  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_NPRX  = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CTRL  = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_ADDAT = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_STAT  = 6'h10;

  // Expansion register fields.
  localparam int EXP_PDF   = 4;
  localparam int EXP_LPNP  = 3;
  localparam int EXP_LOCNP = 2;
  localparam int EXP_PRX   = 1;
  localparam int EXP_LPAN  = 0;

  // Transmit next page fields, reset value and writable bits.
  localparam int          NP_TOG     = 11;
  localparam logic [15:0] NPTX_RST   = 16'h2001;
  localparam logic [15:0] NPTX_WMASK = 16'hb7ff;

  // Partner base page implemented bits; bit 12 is reserved.
  localparam logic [15:0] BASE_MASK  = 16'hefff;

  // Indirect access control fields and function codes.
  localparam int         CTRL_FN_HI  = 15;
  localparam int         CTRL_FN_LO  = 14;
  localparam int         CTRL_DEV_HI = 4;
  localparam logic [1:0] FN_ADDR     = 2'b00;
  localparam logic [1:0] FN_DATA     = 2'b01;
  localparam logic [1:0] FN_INC_RW   = 2'b10;
  localparam logic [1:0] FN_INC_WR   = 2'b11;

  // Fast-link status extension fields and self-clearing bits.
  localparam int          ST_LOCKED  = 15;
  localparam int          ST_LOCKERR = 14;
  localparam int          ST_DISC    = 13;
  localparam int          ST_LINK    = 12;
  localparam int          ST_RXERR   = 11;
  localparam int          ST_TXERR   = 10;
  localparam int          ST_SSD     = 9;
  localparam int          ST_ESD     = 8;
  localparam logic [15:0] SC_MASK    = 16'h6f00;

  // APB request and answer.
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  // Auto-negotiation side inputs.
  typedef struct packed {
    logic        base_load;
    logic [15:0] base_page;
    logic        np_load;
    logic [15:0] np_page;
    logic        page_rx;
    logic        pd_fault;
    logic        lp_np_able;
    logic        lp_an_able;
    logic        lcw_sent;
    logic        lcw_toggle;
  } an_in_s;

  // Fast-link receive and transmit status inputs.
  typedef struct packed {
    logic locked;
    logic link_up;
    logic lock_err;
    logic disconnect;
    logic rx_err;
    logic tx_err;
    logic ssd_err;
    logic esd_err;
  } fast_in_s;

  // Indirect access strobes towards the MMD register store.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mmd_req_s;

endpackage

// File: phy_autoneg_page_status_regs.sv
// Management register group for partner pages, expansion, next page, indirect MMD window and fast-link status.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module phy_autoneg_page_status_regs (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire phy_an_regs_pkg::apb_req_s apb_i,
  output phy_an_regs_pkg::apb_rsp_s      apb_o,
  input  wire phy_an_regs_pkg::an_in_s   an_i,
  input  wire phy_an_regs_pkg::fast_in_s fast_i,
  input  wire logic [15:0]               mmd_rdata_i,
  output phy_an_regs_pkg::mmd_req_s      mmd_o,
  output logic [15:0]                    np_tx_o
);
  import phy_an_regs_pkg::*;

  // Matches a bus address against one register index, aligned words only.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] code);
    reg_hit = (a[ADDR_W-1:2] == code) && (a[1:0] == 2'b00);
  endfunction

  logic [15:0] base_r;
  logic [15:0] nprx_r;
  logic        pdf_r;
  logic        prx_r;
  logic        lpnp_r;
  logic        lpan_r;
  logic [15:0] nptx_r;
  logic        tog_r;
  logic [1:0]  fn_r;
  logic [4:0]  dev_r;
  logic [15:0] maddr_r;
  logic [15:0] wdata_r;
  logic [15:0] flags_r;
  logic [15:0] prdata_r;
  logic [15:0] rd_word;
  logic [15:0] ev_vec;

  // Bus phase decode and register selection.
  wire setup    = apb_i.psel && !apb_i.penable;
  wire acc      = apb_i.psel && apb_i.penable;
  wire hit_base = reg_hit(apb_i.paddr, IDX_BASE);
  wire hit_exp  = reg_hit(apb_i.paddr, IDX_EXP);
  wire hit_nptx = reg_hit(apb_i.paddr, IDX_NPTX);
  wire hit_nprx = reg_hit(apb_i.paddr, IDX_NPRX);
  wire hit_ctrl = reg_hit(apb_i.paddr, IDX_CTRL);
  wire hit_ad   = reg_hit(apb_i.paddr, IDX_ADDAT);
  wire hit_stat = reg_hit(apb_i.paddr, IDX_STAT);
  wire mapped   = hit_base | hit_exp | hit_nptx | hit_nprx | hit_ctrl | hit_ad | hit_stat;
  wire wr_acc   = acc && apb_i.pwrite && mapped;
  wire rd_acc   = acc && !apb_i.pwrite && mapped;

  // Zero wait states; an unmapped or misaligned address answers with an error.
  assign apb_o = '{pready: 1'b1, pslverr: acc && !mapped, prdata: {16'h0000, prdata_r}};

  // Read-clear strobes; only the bits captured at setup are cleared.
  wire clr_exp  = rd_acc && hit_exp;
  wire clr_stat = rd_acc && hit_stat;

  // Event vector laid out as register 16.
  always_comb
  begin
    ev_vec             = 16'h0000;
    ev_vec[ST_LOCKERR] = fast_i.lock_err;
    ev_vec[ST_DISC]    = fast_i.disconnect;
    ev_vec[ST_RXERR]   = fast_i.rx_err;
    ev_vec[ST_TXERR]   = fast_i.tx_err;
    ev_vec[ST_SSD]     = fast_i.ssd_err;
    ev_vec[ST_ESD]     = fast_i.esd_err;
  end

  wire [15:0] flags_nxt = (flags_r & ~(clr_stat ? (prdata_r & SC_MASK) : 16'h0000)) | ev_vec;
  wire        pdf_nxt   = (pdf_r && !(clr_exp && prdata_r[EXP_PDF])) || an_i.pd_fault;
  wire        prx_nxt   = (prx_r && !(clr_exp && prdata_r[EXP_PRX])) || an_i.page_rx;

  // Indirect window strobes.
  // address or data
  wire ad_wr_addr = wr_acc && hit_ad && (fn_r == FN_ADDR);
  assign mmd_o = '{wr:    wr_acc && hit_ad && (fn_r != FN_ADDR),
                   rd:    rd_acc && hit_ad && (fn_r != FN_ADDR),
                   dev:   dev_r,
                   addr:  maddr_r,
                   wdata: wdata_r};

  wire inc = (mmd_o.wr && ((fn_r == FN_INC_RW) || (fn_r == FN_INC_WR))) || (mmd_o.rd && (fn_r == FN_INC_RW));
  wire [15:0] maddr_nxt = ad_wr_addr ? apb_i.pwdata[15:0] : (inc ? 16'(maddr_r + 16'h0001) : maddr_r);

  wire [15:0] nptx_nxt = (wr_acc && hit_nptx) ? (apb_i.pwdata[15:0] & NPTX_WMASK) : nptx_r;

  wire tog_nxt = an_i.lcw_sent ? !an_i.lcw_toggle : tog_r;

  // Page sent to the auto-negotiation transmitter.
  assign np_tx_o = nptx_r | ({15'h0000, tog_r} << NP_TOG);

  // Read multiplexer; reserved and unmapped bits read zero.
  always_comb
  begin
    rd_word = 16'h0000;
    if (hit_base)
      rd_word = base_r;
    if (hit_exp)
    begin
      rd_word[EXP_PDF]   = pdf_r;
      rd_word[EXP_LPNP]  = lpnp_r;
      rd_word[EXP_LOCNP] = 1'b1;
      rd_word[EXP_PRX]   = prx_r;
      rd_word[EXP_LPAN]  = lpan_r;
    end
    if (hit_nptx)
      rd_word = np_tx_o;
    if (hit_nprx)
      rd_word = nprx_r;
    if (hit_ctrl)
      rd_word = {fn_r, 9'h000, dev_r};
    if (hit_ad)
      rd_word = (fn_r == FN_ADDR) ? maddr_r : mmd_rdata_i;
    if (hit_stat)
    begin
      rd_word           = flags_r & SC_MASK;
      rd_word[ST_LOCKED] = fast_i.locked;
      rd_word[ST_LINK]   = fast_i.link_up;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      prdata_r <= 16'h0000;
    else if (setup)
      prdata_r <= apb_i.pwrite ? 16'h0000 : rd_word;
  end

  // Write data for the indirect window is captured in the setup cycle.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      wdata_r <= 16'h0000;
    else if (setup)
      wdata_r <= apb_i.pwdata[15:0];
  end

  // Partner pages and ability levels from the auto-negotiation logic.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      base_r <= 16'h0000;
      nprx_r <= 16'h0000;
      lpnp_r <= 1'b0;
      lpan_r <= 1'b0;
    end
    else
    begin
      if (an_i.base_load)
        base_r <= an_i.base_page & BASE_MASK;
      if (an_i.np_load)
        nprx_r <= an_i.np_page;
      lpnp_r <= an_i.lp_np_able;
      lpan_r <= an_i.lp_an_able;
    end
  end

  // Latched expansion bits and self-clearing status flags.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pdf_r   <= 1'b0;
      prx_r   <= 1'b0;
      flags_r <= 16'h0000;
    end
    else
    begin
      pdf_r   <= pdf_nxt;
      prx_r   <= prx_nxt;
      flags_r <= flags_nxt & SC_MASK;
    end
  end

  // Transmit next page register and toggle.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      nptx_r <= NPTX_RST;
      tog_r  <= 1'b0;
    end
    else
    begin
      nptx_r <= nptx_nxt;
      tog_r  <= tog_nxt;
    end
  end

  // Indirect access control and address pointer.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      fn_r    <= FN_ADDR;
      dev_r   <= 5'h00;
      maddr_r <= 16'h0000;
    end
    else
    begin
      if (wr_acc && hit_ctrl)
      begin
        fn_r  <= apb_i.pwdata[CTRL_FN_HI:CTRL_FN_LO];
        dev_r <= apb_i.pwdata[CTRL_DEV_HI:0];
      end
      maddr_r <= maddr_nxt;
    end
  end

  // Checks on the register behaviour.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_base_hold;
    !an_i.base_load |=> $stable(base_r);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("Partner base page changed without a load.");

  property p_pdf_latch;
    pdf_r && !clr_exp |=> pdf_r;
  endproperty
  a_pdf_latch: assert property (p_pdf_latch) else $error("Parallel fault bit dropped without a read.");

  property p_prx_set;
    an_i.page_rx |=> prx_r ##1 (prx_r || $past(clr_exp));
  endproperty
  a_prx_set: assert property (p_prx_set) else $error("Page received bit not latched.");

  property p_local_np;
    setup && hit_exp && !apb_i.pwrite |=> prdata_r[EXP_LOCNP];
  endproperty
  a_local_np: assert property (p_local_np) else $error("Local next page bit not read as one.");

  property p_toggle;
    an_i.lcw_sent |=> np_tx_o[NP_TOG] == !$past(an_i.lcw_toggle);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle is not the inverse of the sent toggle.");

  property p_inc_write;
    mmd_o.wr && (fn_r == FN_INC_WR) |=> maddr_r == 16'($past(maddr_r) + 16'h0001);
  endproperty
  a_inc_write: assert property (p_inc_write) else $error("Address did not advance after a data write.");

  property p_no_inc_read;
    mmd_o.rd && (fn_r == FN_INC_WR) |=> $stable(maddr_r);
  endproperty
  a_no_inc_read: assert property (p_no_inc_read) else $error("Address advanced after a data read.");

  property p_addr_load;
    ad_wr_addr |=> maddr_r == $past(apb_i.pwdata[15:0]);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("Address mode write did not load the pointer.");

  property p_live_lock;
    setup && hit_stat && !apb_i.pwrite |=> prdata_r[ST_LOCKED] == $past(fast_i.locked);
  endproperty
  a_live_lock: assert property (p_live_lock) else $error("Lock bit does not follow the live state.");

  property p_rx_err_set;
    fast_i.rx_err |=> flags_r[ST_RXERR];
  endproperty
  a_rx_err_set: assert property (p_rx_err_set) else $error("Receive error flag not set.");

  property p_clear_on_read;
    clr_stat && (ev_vec == 16'h0000) |=> (flags_r & $past(prdata_r)) == 16'h0000;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("Read flags were not cleared.");

  property p_ctrl_reserved;
    setup && hit_ctrl |=> prdata_r[13:5] == 9'h000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("Reserved control bits not zero.");

  property p_partner_base_ability;
    1'b1 |=> (lpnp_r == $past(an_i.lp_np_able)) && (lpan_r == $past(an_i.lp_an_able));
  endproperty
  a_partner_base_ability: assert property (p_partner_base_ability) else $error("Partner ability bits do not follow their inputs.");

  property p_nptx_write;
    wr_acc && hit_nptx |=> (np_tx_o & NPTX_WMASK) == ($past(apb_i.pwdata[15:0]) & NPTX_WMASK);
  endproperty
  a_nptx_write: assert property (p_nptx_write) else $error("Writable next page fields not taken.");

  property p_np_load;
    an_i.np_load |=> nprx_r == $past(an_i.np_page);
  endproperty
  a_np_load: assert property (p_np_load) else $error("Partner next page not loaded.");

  property p_fn_write;
    wr_acc && hit_ctrl |=> (fn_r == $past(apb_i.pwdata[CTRL_FN_HI:CTRL_FN_LO]))
                           && (dev_r == $past(apb_i.pwdata[CTRL_DEV_HI:0]));
  endproperty
  a_fn_write: assert property (p_fn_write) else $error("Control write did not set function and device.");

  property p_inc_rw_read;
    mmd_o.rd && (fn_r == FN_INC_RW) |=> maddr_r == 16'($past(maddr_r) + 16'h0001);
  endproperty
  a_inc_rw_read: assert property (p_inc_rw_read) else $error("Address did not advance after a data read.");

  property p_lock_err_set;
    fast_i.lock_err |=> flags_r[ST_LOCKERR];
  endproperty
  a_lock_err_set: assert property (p_lock_err_set) else $error("Lock error flag not set.");

  property p_disc_set;
    fast_i.disconnect |=> flags_r[ST_DISC];
  endproperty
  a_disc_set: assert property (p_disc_set) else $error("Disconnect flag not set.");

  property p_tx_err_set;
    fast_i.tx_err |=> flags_r[ST_TXERR];
  endproperty
  a_tx_err_set: assert property (p_tx_err_set) else $error("Transmit error flag not set.");

  property p_esd_set;
    fast_i.esd_err |=> flags_r[ST_ESD];
  endproperty
  a_esd_set: assert property (p_esd_set) else $error("End delimiter error flag not set.");

  property p_cov_inc_read;
    mmd_o.rd && (fn_r == FN_INC_RW);
  endproperty
  c_cov_inc_read: cover property (p_cov_inc_read);

  property p_cov_clear;
    clr_stat && (prdata_r != 16'h0000);
  endproperty
  c_cov_clear: cover property (p_cov_clear);

  property p_cov_page;
    an_i.page_rx ##[1:20] clr_exp;
  endproperty
  c_cov_page: cover property (p_cov_page);

  property p_cov_inc_write;
    mmd_o.wr && (fn_r == FN_INC_WR);
  endproperty
  c_cov_inc_write: cover property (p_cov_inc_write);

endmodule

// File: mmd_store_model.sv
// Behavioural MMD register store that answers the indirect access window.
`timescale 1ns/10ps
module mmd_store_model (
  input  wire logic                      clock_i,
  input  wire phy_an_regs_pkg::mmd_req_s mmd_i,
  output logic [15:0]                    rdata_o
);
  import phy_an_regs_pkg::*;

  // Start from a cleared store so that every expected read is known.
  logic [15:0] mem_r [16] = '{default: 16'h0000};

  // Read data follows the addressed word at once; the device number is folded in so a wrong device shows.
  // data read path
  assign rdata_o = mem_r[mmd_i.addr[3:0]] ^ {11'h000, mmd_i.dev};

  // Store one word on each data write strobe.
  // data write path
  always @(posedge clock_i)
  begin
    if (mmd_i.wr === 1'b1) mem_r[mmd_i.addr[3:0]] <= mmd_i.wdata;
  end
endmodule

// File: phy_autoneg_page_status_regs_bench.sv
// Self-checking bench for the page, expansion, indirect window and fast-link status registers.
`timescale 1ns/10ps
module phy_autoneg_page_status_regs_bench;
  import phy_an_regs_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [5:0]  idx;
    logic [15:0] data;
  } row_s;

  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  apb_req_s    req     = '0;
  apb_rsp_s    rsp;
  an_in_s      an      = '0;
  fast_in_s    fast    = '0;
  mmd_req_s    mmd;
  logic [15:0] mmd_rdata;
  logic [15:0] np_tx;
  logic [15:0] rd;
  logic        err;
  int          num_errors  = 0;
  int          check_count = 0;
  row_s        rows [14];

  phy_autoneg_page_status_regs uut (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .apb_i       (req),
    .apb_o       (rsp),
    .an_i        (an),
    .fast_i      (fast),
    .mmd_rdata_i (mmd_rdata),
    .mmd_o       (mmd),
    .np_tx_o     (np_tx)
  );

  mmd_store_model store (
    .clock_i (clock_i),
    .mmd_i   (mmd),
    .rdata_o (mmd_rdata)
  );

  // The clock toggles every half period of 4 ns.
  always #4 clock_i = ~clock_i;

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer: setup, then access until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [5:0] idx, input logic [15:0] wd);
    int n;
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {16'h0000, wd}};
    @(posedge clock_i);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    rd  = rsp.prdata[15:0];
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) chk("pready", 16'h0001, 16'h0000);
  endtask

  // Reads a register and compares it.
  task automatic rdc(input logic [5:0] idx, input logic [15:0] exp, input string name);
    apb(1'b0, idx, 16'h0000);
    chk(name, exp, rd);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hung run short.
  initial
  begin
    #40000;
    num_errors++;
    report_and_stop();
  end

  // Main sequence: table of reset values, ignored writes and masked writes, then hand-written cases.
  initial
  begin
    rows = '{'{1'b0, IDX_BASE, 16'h0000}, '{1'b0, IDX_EXP, 16'h0004}, '{1'b0, IDX_NPTX, 16'h2001},
             '{1'b0, IDX_NPRX, 16'h0000}, '{1'b0, IDX_CTRL, 16'h0000}, '{1'b0, IDX_STAT, 16'h0000},
             '{1'b1, IDX_BASE, 16'hffff}, '{1'b0, IDX_BASE, 16'h0000}, '{1'b1, IDX_EXP, 16'hffff},
             '{1'b0, IDX_EXP, 16'h0004}, '{1'b1, IDX_NPTX, 16'hffff}, '{1'b0, IDX_NPTX, 16'hb7ff},
             '{1'b1, IDX_CTRL, 16'hffff}, '{1'b0, IDX_CTRL, 16'hc01f}};
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rows[i])
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].data);
      else rdc(rows[i].idx, rows[i].data, "table row");
    chk("np_tx", 16'hb7ff, np_tx);
    apb(1'b0, 6'h01, 16'h0000);
    chk("unmapped err", 16'h0001, {15'h0000, err});
    // Partner pages and the code word toggle.
    @(posedge clock_i);
    an <= '{base_load: 1'b1, base_page: 16'hffff, np_load: 1'b1, np_page: 16'ha5a5, lcw_sent: 1'b1, default: 1'b0};
    @(posedge clock_i);
    an <= '0;
    rdc(IDX_BASE, 16'hefff, "base page");
    rdc(IDX_NPRX, 16'ha5a5, "next page rx");
    rdc(IDX_NPTX, 16'hbfff, "toggle");
    chk("np_tx toggle", 16'hbfff, np_tx);
    // Latched expansion bits clear only after being read.
    @(posedge clock_i);
    an <= '{pd_fault: 1'b1, page_rx: 1'b1, lp_np_able: 1'b1, lp_an_able: 1'b1, default: '0};
    @(posedge clock_i);
    an <= '{lp_np_able: 1'b1, lp_an_able: 1'b1, default: '0};
    rdc(IDX_EXP, 16'h001f, "exp set");
    rdc(IDX_EXP, 16'h000d, "exp cleared");
    // Fast-link flags, live bits held.
    @(posedge clock_i);
    fast <= 8'hff;
    @(posedge clock_i);
    fast <= '{locked: 1'b1, link_up: 1'b1, default: 1'b0};
    rdc(IDX_STAT, 16'hff00, "stat set");
    rdc(IDX_STAT, 16'h9000, "stat cleared");
    // A receive error that lands on the clearing edge of a read stays pending.
    fork
      rdc(IDX_STAT, 16'h9000, "stat race");
      begin
        repeat (2) @(posedge clock_i);
        fast.rx_err <= 1'b1;
        @(posedge clock_i);
        fast.rx_err <= 1'b0;
      end
    join
    rdc(IDX_STAT, 16'h9800, "stat pending");
    rdc(IDX_STAT, 16'h9000, "stat pending cleared");
    // Indirect window through every function code.
    apb(1'b1, IDX_CTRL, 16'h0003);
    apb(1'b1, IDX_ADDAT, 16'h0004);
    apb(1'b1, IDX_CTRL, 16'hc003);
    apb(1'b1, IDX_ADDAT, 16'h1111);
    @(negedge clock_i);
    chk("ptr after wr", 16'h0005, mmd.addr);
    chk("dev", 16'h0003, {11'h000, mmd.dev});
    rdc(IDX_ADDAT, 16'h0003, "data fn11");
    @(negedge clock_i);
    chk("ptr after rd", 16'h0005, mmd.addr);
    apb(1'b1, IDX_CTRL, 16'h8003);
    rdc(IDX_ADDAT, 16'h0003, "data fn10");
    apb(1'b1, IDX_CTRL, 16'h4003);
    apb(1'b1, IDX_ADDAT, 16'h2222);
    @(negedge clock_i);
    chk("ptr fn01", 16'h0006, mmd.addr);
    apb(1'b1, IDX_CTRL, 16'h0003);
    apb(1'b1, IDX_ADDAT, 16'h0004);
    rdc(IDX_ADDAT, 16'h0004, "ptr read");
    apb(1'b1, IDX_CTRL, 16'h4003);
    rdc(IDX_ADDAT, 16'h1112, "data back");
    // A second reset drops a pending latch and restores defaults.
    @(posedge clock_i);
    an.pd_fault <= 1'b1;
    rst_i       <= 1'b1;
    @(posedge clock_i);
    an <= '0;
    @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(IDX_EXP, 16'h0004, "exp after reset");
    chk("np_tx after reset", 16'h2001, np_tx);
    report_and_stop();
  end
endmodule
